// ==== rtl/aomc_pkg.sv ====
// package: register map, field codes, reset values and numeric formats for aux output control
`default_nettype none
package aomc_pkg;
    // wishbone register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;  // mode, polarity, units, input, range
    localparam logic [7:0] REG_WARMUP  = 8'h04;  // warm-up percentage
    localparam logic [7:0] REG_SETPT   = 8'h08;  // warm-up setpoint
    localparam logic [7:0] REG_SC_NEG  = 8'h0c;  // scale point for negative full scale
    localparam logic [7:0] REG_SC_ZERO = 8'h10;  // scale point for zero volts
    localparam logic [7:0] REG_SC_POS  = 8'h14;  // scale point for positive full scale
    localparam logic [7:0] REG_STATUS  = 8'h18;  // live output state
    localparam logic [7:0] REG_SHUT    = 8'h1c;  // write 1 to bit 0: global output shutdown

    // control register field positions
    localparam int CTL_MODE_LSB  = 0;   // 2 bits
    localparam int CTL_POL_BIT   = 2;   // 1 = bipolar
    localparam int CTL_TYPE_BIT  = 3;   // 1 = voltage output type
    localparam int CTL_UNIT_LSB  = 4;   // 2 bits
    localparam int CTL_SEL_LSB   = 6;   // 3 bits
    localparam int CTL_RANGE_BIT = 9;   // 1 = range on
    localparam int CTL_WCONT_BIT = 10;  // 1 = continuous warm-up
    localparam int CTL_PUE_BIT   = 11;  // power-up enable

    // output modes
    typedef enum logic [1:0] {
        AOMC_OFF    = 2'b00,
        AOMC_CLOSED = 2'b01,
        AOMC_WARMUP = 2'b10,
        AOMC_MONOUT = 2'b11
    } aomc_mode_t;

    // monitor units
    typedef enum logic [1:0] {
        AOMC_U_K    = 2'b00,
        AOMC_U_C    = 2'b01,
        AOMC_U_SENS = 2'b10
    } aomc_unit_t;

    // readings and scale points: signed, 1/10000 of a unit (k, c or sensor)
    localparam int RD_W = 32;
    // dac code: signed 16 bits, +/-32767 is +/-10 v
    localparam int DAC_W = 16;
    localparam logic signed [DAC_W-1:0] DAC_FS   = 16'sh7fff;
    localparam logic signed [DAC_W-1:0] DAC_NFS  = -16'sh7fff;
    localparam logic signed [DAC_W-1:0] DAC_ZERO = 16'sh0000;

    // warm-up percentage limits and default
    localparam logic [6:0] PCT_MAX = 7'h64;  // 100 percent
    localparam logic [6:0] PCT_RST = 7'h64;
    // one kelvin hysteresis in reading units
    localparam logic signed [RD_W-1:0] HYST_1K = 32'sh0000_2710;
    // scale point defaults
    localparam logic signed [RD_W-1:0] SC_NEG_RST  = 32'sh0000_0000;  // 0.0000 k
    localparam logic signed [RD_W-1:0] SC_ZERO_RST = 32'sh0000_0000;  // 0.0000 k
    localparam logic signed [RD_W-1:0] SC_POS_RST  = 32'sh0098_9680;  // 1000 k
    // acceptable limits per unit
    localparam logic signed [RD_W-1:0] K_MIN = 32'sh0000_0000;   // 0 k
    localparam logic signed [RD_W-1:0] K_MAX = 32'sh0098_9680;   // 1000 k
    localparam logic signed [RD_W-1:0] C_MIN = -32'sh0029_adec;  // -273.15 c
    localparam logic signed [RD_W-1:0] C_MAX = 32'sh006e_e894;   // 726.85 c ( = 1000 k)
    localparam logic signed [RD_W-1:0] S_MIN = 32'sh0000_0000;
    localparam logic signed [RD_W-1:0] S_MAX = 32'sh05f5_e100;   // 10000 sensor units
    // ctrl reset value: continuous warm-up, unipolar, kelvin, input none
    localparam logic [11:0] CTRL_RST = 12'h400;
endpackage
`default_nettype wire

// ==== rtl/aomc_top.sv ====
// aux output mode control: closed loop, warm-up supply and monitor-out dac drive
// Functional notes
// [R1] bipolar closed loop needs voltage type, bipolar
// [R2] warm-up on drives full scale times percentage
// [R3] warm-up percentage 0 to 100, default 100
// [R4] warm-up active only when range on
// [R5] auto-off: at setpoint drive zero, range off
// [R6] range on again restarts auto-off cycle
// [R7] continuous: off at setpoint, on 1 K below
// [R8] continuous never clears range itself
// [R9] power-up enable decides range restore after power
// [R10] monitor tracks selected input, default none
// [R11] monitor always enabled, ignores global shutdown
// [R12] monitor units kelvin, celsius or sensor
// [R13] scale points use selected monitor units
// [R14] polarity picks unipolar or bipolar span
// [R15] output linear between bottom and top points
// [R16] defaults unipolar, 0 K, 0 K, 1000 K
// [R17] scale points clamped to unit limits
// [R18] monitor output saturates beyond scale points
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`default_nettype none
module aomc_top (
    // clock and reset
    input  wire logic                I_CLOCK,
    input  wire logic                I_RST_B,
    // power-on restore strobe from instrument supervisor
    input  wire logic                I_POWER_RESTORE,
    // sensor readings a..d in kelvin, celsius and sensor units
    input  wire logic [4*32-1:0]     I_READ_K,
    input  wire logic [4*32-1:0]     I_READ_C,
    input  wire logic [4*32-1:0]     I_READ_S,
    // closed-loop pid demand, signed dac code
    input  wire logic signed [15:0]  I_PID_CODE,
    // wishbone classic slave
    input  wire logic                I_WB_CYC,
    input  wire logic                I_WB_STB,
    input  wire logic                I_WB_WE,
    input  wire logic [7:0]          I_WB_ADR,
    input  wire logic [3:0]          I_WB_SEL,
    input  wire logic [31:0]         I_WB_DAT,
    output logic [31:0]              O_WB_DAT,
    output logic                     O_WB_ACK,
    // dac drive
    output logic signed [15:0]       O_DAC_CODE,
    output logic                     O_OUT_ACTIVE
);
    // reading and scale point width
    localparam int RW = aomc_pkg::RD_W;

    // configuration and loop state registers
    logic [11:0]              ctrl_q;      // control fields
    logic [6:0]               pct_q;       // warm-up percentage
    logic signed [RW-1:0]     setpt_q;     // warm-up setpoint (kelvin)
    logic signed [RW-1:0]     sc_neg_q;    // scale point -fs
    logic signed [RW-1:0]     sc_zero_q;   // scale point 0 v
    logic signed [RW-1:0]     sc_pos_q;    // scale point +fs
    logic                     warm_on_q;   // warm-up drive state
    logic                     shut_q;      // global shutdown latched
    logic                     pue_q;       // range remembered for power restore
    logic signed [15:0]       code_d;      // next dac code

    // decoded control fields
    logic [1:0]  mode;
    logic        bipolar, vtype, range_on, wcont;
    logic [1:0]  units;
    logic [2:0]  sel;
    assign mode     = ctrl_q[aomc_pkg::CTL_MODE_LSB +: 2];
    assign bipolar  = ctrl_q[aomc_pkg::CTL_POL_BIT];
    assign vtype    = ctrl_q[aomc_pkg::CTL_TYPE_BIT];
    assign units    = ctrl_q[aomc_pkg::CTL_UNIT_LSB +: 2];
    assign sel      = ctrl_q[aomc_pkg::CTL_SEL_LSB +: 3];
    assign range_on = ctrl_q[aomc_pkg::CTL_RANGE_BIT];
    assign wcont    = ctrl_q[aomc_pkg::CTL_WCONT_BIT];

    // bus strobes
    // writes need all byte lanes; partial writes are acked only
    logic wr, rd_req;
    assign wr     = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK && (&I_WB_SEL);
    assign rd_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;

    // feedback temperature (kelvin) of selected input, zero for none
    logic signed [RW-1:0] fb_k, mon_rd;
    always_comb begin
        fb_k   = '0;
        mon_rd = '0;
        if (sel >= 3'h1 && sel <= 3'h4) begin
            // control loop feedback is always in kelvin
            fb_k = I_READ_K[(sel-3'h1)*32 +: 32];  // [R4]
            // monitor reading in the selected units
            case (units)  // [R12]
                aomc_pkg::AOMC_U_C:    mon_rd = I_READ_C[(sel-3'h1)*32 +: 32];
                aomc_pkg::AOMC_U_SENS: mon_rd = I_READ_S[(sel-3'h1)*32 +: 32];
                default:               mon_rd = I_READ_K[(sel-3'h1)*32 +: 32];
            endcase
        end
    end

    // scale point clamp to current unit limits
    function automatic logic signed [RW-1:0] clamp_pt(input logic signed [RW-1:0] v,
                                                      input logic [1:0] u);
        logic signed [RW-1:0] lo, hi;
        // kelvin limits unless another unit is selected
        lo = aomc_pkg::K_MIN;
        hi = aomc_pkg::K_MAX;
        if (u == aomc_pkg::AOMC_U_C) begin
            lo = aomc_pkg::C_MIN;
            hi = aomc_pkg::C_MAX;
        end else if (u == aomc_pkg::AOMC_U_SENS) begin
            lo = aomc_pkg::S_MIN;
            hi = aomc_pkg::S_MAX;
        end
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction

    // warm-up setpoint reached / hysteresis
    logic at_setpt, below_hyst, auto_off;
    assign at_setpt   = fb_k >= setpt_q;
    assign below_hyst = fb_k <= setpt_q - aomc_pkg::HYST_1K;  // [R7]
    assign auto_off   = mode == aomc_pkg::AOMC_WARMUP && range_on && !wcont && at_setpt;  // [R5]

    // control register: software writes, auto-off clear, power restore
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ctrl_q <= aomc_pkg::CTRL_RST;  // [R16]
        end else if (wr && I_WB_ADR == aomc_pkg::REG_CTRL) begin
            ctrl_q <= I_WB_DAT[11:0];  // [R6]
        end else if (auto_off) begin
            ctrl_q[aomc_pkg::CTL_RANGE_BIT] <= 1'b0;  // [R5] [R8]
        end else if (I_POWER_RESTORE) begin
            ctrl_q[aomc_pkg::CTL_RANGE_BIT] <= pue_q;  // [R9]
        end
    end

    // remembered range for power restore, only when power-up enable set
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pue_q <= 1'b0;
        end else begin
            pue_q <= ctrl_q[aomc_pkg::CTL_PUE_BIT] && range_on;  // [R9]
        end
    end

    // percentage and setpoint registers
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pct_q   <= aomc_pkg::PCT_RST;  // [R3]
            setpt_q <= '0;
        end else if (wr) begin
            if (I_WB_ADR == aomc_pkg::REG_WARMUP) begin
                // values above 100 percent limited
                pct_q <= (I_WB_DAT[31:7] != '0 || I_WB_DAT[6:0] > aomc_pkg::PCT_MAX)
                         ? aomc_pkg::PCT_MAX : I_WB_DAT[6:0];  // [R3]
            end
            if (I_WB_ADR == aomc_pkg::REG_SETPT) begin
                setpt_q <= I_WB_DAT;
            end
        end
    end

    // scale points, limited to unit range on write and on unit change
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sc_neg_q  <= aomc_pkg::SC_NEG_RST;   // [R16]
            sc_zero_q <= aomc_pkg::SC_ZERO_RST;  // [R16]
            sc_pos_q  <= aomc_pkg::SC_POS_RST;   // [R16]
        end else if (wr && I_WB_ADR == aomc_pkg::REG_SC_NEG) begin
            sc_neg_q <= clamp_pt(I_WB_DAT, units);  // [R17] [R13]
        end else if (wr && I_WB_ADR == aomc_pkg::REG_SC_ZERO) begin
            sc_zero_q <= clamp_pt(I_WB_DAT, units);  // [R17]
        end else if (wr && I_WB_ADR == aomc_pkg::REG_SC_POS) begin
            sc_pos_q <= clamp_pt(I_WB_DAT, units);  // [R17]
        end else begin
            // keep stored points inside limits after a unit change
            sc_neg_q  <= clamp_pt(sc_neg_q, units);   // [R17]
            sc_zero_q <= clamp_pt(sc_zero_q, units);  // [R17]
            sc_pos_q  <= clamp_pt(sc_pos_q, units);   // [R17]
        end
    end

    // global shutdown latch: set by write, cleared by any range-on write
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            shut_q <= 1'b0;
        end else if (wr && I_WB_ADR == aomc_pkg::REG_SHUT) begin
            shut_q <= I_WB_DAT[0];
        end else if (wr && I_WB_ADR == aomc_pkg::REG_CTRL
                     && I_WB_DAT[aomc_pkg::CTL_RANGE_BIT]) begin
            // turning a range on again releases the shutdown
            shut_q <= 1'b0;
        end
    end

    // warm-up on/off state
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            warm_on_q <= 1'b0;
        end else if (mode != aomc_pkg::AOMC_WARMUP || !range_on || shut_q) begin
            // not in warm-up, range off or shut down: output off
            warm_on_q <= 1'b0;  // [R4]
        end else if (at_setpt) begin
            // setpoint reached: off in both control options
            warm_on_q <= 1'b0;  // [R5] [R7]
        end else if (!warm_on_q && (!wcont || below_hyst)) begin
            // auto-off turns on at once, continuous waits 1 K below
            warm_on_q <= 1'b1;  // [R6] [R7] [R8]
        end
    end

    // monitor scaling: linear map between bottom and top points
    logic signed [RW-1:0] bot;
    logic signed [RW:0]   span, pos;
    logic signed [RW+17:0] prod;
    logic signed [RW+17:0] quo;
    logic signed [15:0]   mon_code, lo_code;
    always_comb begin
        bot  = bipolar ? sc_neg_q : sc_zero_q;  // [R15] [R14]
        span = {sc_pos_q[RW-1], sc_pos_q} - {bot[RW-1], bot};
        pos  = {mon_rd[RW-1], mon_rd} - {bot[RW-1], bot};
        lo_code = bipolar ? aomc_pkg::DAC_NFS : aomc_pkg::DAC_ZERO;  // [R14]
        prod = '0;
        quo  = '0;
        mon_code = lo_code;
        if (span <= 0 || pos <= 0) begin
            // empty span or reading at or below the bottom point
            mon_code = lo_code;  // [R18]
        end else if (pos >= span) begin
            // reading at or above the top point
            mon_code = aomc_pkg::DAC_FS;  // [R18]
        end else begin
            // full span is fs - lo, i.e. 32767 or 65534 codes
            prod = (RW+18)'(pos) * (RW+18)'(bipolar ? 17'sh0fffe : 17'sh07fff);
            quo  = prod / (RW+18)'(span);  // [R15]
            mon_code = 16'(quo[16:0] + 17'(lo_code));
        end
    end

    // output code select per mode
    always_comb begin
        case (aomc_mode_sel(mode))
            aomc_pkg::AOMC_CLOSED: begin
                // only a bipolar voltage output may swing negative
                if (vtype && bipolar && range_on && !shut_q) begin
                    // the most negative code lies past -10 v, hold it at the span end
                    if (I_PID_CODE < aomc_pkg::DAC_NFS) begin
                        code_d = aomc_pkg::DAC_NFS;  // [R1]
                    end else begin
                        code_d = I_PID_CODE;  // [R1]
                    end
                end else if (range_on && !shut_q && I_PID_CODE > 0) begin
                    // unipolar drive: demand clipped at zero
                    code_d = I_PID_CODE;
                end else begin
                    code_d = aomc_pkg::DAC_ZERO;
                end
            end
            aomc_pkg::AOMC_WARMUP: begin
                code_d = warm_on_q
                    ? 16'((32'(aomc_pkg::DAC_FS) * 32'(pct_q)) / 32'(aomc_pkg::PCT_MAX))  // [R2]
                    : aomc_pkg::DAC_ZERO;  // [R5] [R7]
            end
            aomc_pkg::AOMC_MONOUT: begin
                // no range gate and no shutdown gate
                code_d = (sel == 3'h0) ? aomc_pkg::DAC_ZERO : mon_code;  // [R10] [R11]
            end
            default: code_d = aomc_pkg::DAC_ZERO;
        endcase
    end

    // raw mode field seen as the mode type
    function automatic aomc_pkg::aomc_mode_t aomc_mode_sel(input logic [1:0] m);
        return aomc_pkg::aomc_mode_t'(m);
    endfunction

    // registered dac drive and active flag
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_DAC_CODE   <= aomc_pkg::DAC_ZERO;
            O_OUT_ACTIVE <= 1'b0;
        end else begin
            O_DAC_CODE   <= code_d;
            O_OUT_ACTIVE <= code_d != aomc_pkg::DAC_ZERO;
        end
    end

    // wishbone ack and read data, one wait-free cycle
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= '0;
        end else begin
            O_WB_ACK <= rd_req;
            case (I_WB_ADR)
                aomc_pkg::REG_CTRL:    O_WB_DAT <= {20'h00000, ctrl_q};
                aomc_pkg::REG_WARMUP:  O_WB_DAT <= {25'h0, pct_q};
                aomc_pkg::REG_SETPT:   O_WB_DAT <= setpt_q;
                aomc_pkg::REG_SC_NEG:  O_WB_DAT <= sc_neg_q;
                aomc_pkg::REG_SC_ZERO: O_WB_DAT <= sc_zero_q;
                aomc_pkg::REG_SC_POS:  O_WB_DAT <= sc_pos_q;
                aomc_pkg::REG_STATUS:  O_WB_DAT <= {code_d, 13'h0, shut_q, warm_on_q, range_on};
                aomc_pkg::REG_SHUT:    O_WB_DAT <= {31'h0, shut_q};
                default:               O_WB_DAT <= '0;  // unmapped reads zero
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verification/aomc_sva.sv ====
// checker for the aux output control block ports
`default_nettype none
module aomc_sva (
    // clock, reset and bus
    input wire logic               I_CLOCK,
    input wire logic               I_RST_B,
    input wire logic               I_WB_CYC,
    input wire logic               I_WB_STB,
    input wire logic               I_WB_WE,
    input wire logic [7:0]         I_WB_ADR,
    input wire logic [3:0]         I_WB_SEL,
    input wire logic [31:0]        I_WB_DAT,
    input wire logic               O_WB_ACK,
    // dac drive
    input wire logic signed [15:0] O_DAC_CODE,
    input wire logic               O_OUT_ACTIVE
);
    logic [11:0]        ctl_q;  // shadow of the control word
    logic [6:0]         pct_q;  // shadow of the warm-up percentage
    logic               wr;     // full word write accepted
    logic signed [15:0] warm_c; // warm-up drive level
    assign wr = O_WB_ACK && I_WB_CYC && I_WB_STB && I_WB_WE && (I_WB_SEL == 4'hf);
    assign warm_c = 16'((32'h7fff * {25'h0, pct_q}) / 32'h64);
    // shadows follow accepted writes
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ctl_q <= aomc_pkg::CTRL_RST;
            pct_q <= aomc_pkg::PCT_RST;
        end else if (wr && I_WB_ADR == aomc_pkg::REG_CTRL) begin
            ctl_q <= I_WB_DAT[11:0];
        end else if (wr && I_WB_ADR == aomc_pkg::REG_WARMUP) begin
            pct_q <= (I_WB_DAT > 32'h64) ? 7'h64 : I_WB_DAT[6:0];
        end
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);
    a_ack_answers: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
        else $error("no ack after request");
    a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held");
    a_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
        else $error("ack without request");
    a_active_flag: assert property (O_OUT_ACTIVE == (O_DAC_CODE != 16'sh0))
        else $error("active flag wrong");
    a_code_span: assert property (O_DAC_CODE != 16'sh8000) else $error("code off span");
    a_off_zero: assert property (ctl_q[1:0] == 2'h0 && $past(ctl_q[1:0]) == 2'h0
        |-> O_DAC_CODE == 16'sh0) else $error("off mode drives");
    a_unipolar_mon: assert property (ctl_q[1:0] == 2'h3 && !ctl_q[2] && $stable(ctl_q)
        |-> !O_DAC_CODE[15]) else $error("unipolar negative");
    a_closed_clip: assert property (ctl_q[1:0] == 2'h1 && !(ctl_q[2] && ctl_q[3])
        && $stable(ctl_q) |-> !O_DAC_CODE[15]) else $error("bipolar without voltage");
    a_warm_levels: assert property (ctl_q[1:0] == 2'h2 && $stable(ctl_q) && $stable(pct_q)
        |-> O_DAC_CODE == 16'sh0 || O_DAC_CODE == warm_c) else $error("warm level wrong");
endmodule
`default_nettype wire

// ==== verification/aomc_daq_model.sv ====
// acquisition input or supply control input fed by the dac output
`default_nettype none
module aomc_daq_model (
    // clock and dac drive
    input  wire logic               i_clk,
    input  wire logic signed [15:0] i_code,
    input  wire logic               i_active,
    // sampled level in millivolts and supply on flag
    output var int                  o_mv,
    output logic                    o_on
);
    // samples the level once a cycle; +/-32767 is +/-10 v
    always_ff @(posedge i_clk) begin
        o_mv <= (int'(i_code) * 10000) / 32767;
        o_on <= i_active;
    end
endmodule
`default_nettype wire

// ==== verification/aomc_tb.sv ====
// self-checking bench for the aux output control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 0, rst_b = 0, pwr = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0]         adr = 8'h00;
    logic [3:0]         sel = 4'hf;
    logic [31:0]        dat = 32'h0, rdat, dout;
    logic [127:0]       rk = '0, rc = '0, rs = '0;
    logic signed [15:0] pid = 16'sh0, code;
    logic               ack, act, on;
    int                 mv, errors = 0, total_checks = 0;
    always #4 clk = ~clk;
    aomc_top u_aomc_top (.I_CLOCK(clk), .I_RST_B(rst_b), .I_POWER_RESTORE(pwr),
        .I_READ_K(rk), .I_READ_C(rc), .I_READ_S(rs), .I_PID_CODE(pid), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
        .O_WB_DAT(dout), .O_WB_ACK(ack), .O_DAC_CODE(code), .O_OUT_ACTIVE(act));
    aomc_daq_model u_aomc_daq_model (.i_clk(clk), .i_code(code), .i_active(act),
        .o_mv(mv), .o_on(on));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one classic cycle, waits for ack under a bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (ack !== 1'b1) begin
            errors++;
            conclude();
        end
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask
    // dac code at the port, and the active flag as the far side sees it
    task automatic cchk(input string nm, input logic signed [15:0] e);
        settle();
        check(nm, {16'h0, code}, {16'h0, e});
        check({nm, "_active"}, {31'h0, on}, {31'h0, e != 16'sh0});
    endtask
    task automatic mvchk(input string nm, input int e);
        settle();
        check(nm, {31'h0, (^code !== 1'bx) && mv - e <= 2 && e - mv <= 2}, 32'h1);
    endtask
    // expected monitor level in millivolts, saturating past the points
    function automatic int mon_mv(input longint r, input longint lo, input longint hi,
        input bit bip);
        longint b;
        b = bip ? -10000 : 0;
        if (r <= lo) return int'(b);
        if (r >= hi) return 10000;
        return int'(b + (r - lo) * (10000 - b) / (hi - lo));
    endfunction
    initial begin
        logic [31:0] rv [5];
        logic [7:0]  ra [5];
        int          r;
        ra = '{aomc_pkg::REG_CTRL, aomc_pkg::REG_WARMUP, aomc_pkg::REG_SC_NEG,
            aomc_pkg::REG_SC_ZERO, aomc_pkg::REG_SC_POS};
        rv = '{{20'h0, aomc_pkg::CTRL_RST}, {25'h0, aomc_pkg::PCT_RST}, aomc_pkg::SC_NEG_RST,
            aomc_pkg::SC_ZERO_RST, aomc_pkg::SC_POS_RST};
        void'($urandom(89));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i]);
            check("reset_value", rdat, rv[i]);
        end
        rd(8'h20);
        check("unmapped", rdat, 32'h0);
        wr(aomc_pkg::REG_WARMUP, 32'h96);
        wb(1'b1, aomc_pkg::REG_WARMUP, 32'h0a, 4'h3);
        rd(aomc_pkg::REG_WARMUP);
        check("pct_clamp", rdat, 32'h64);
        r = $urandom % 101;
        wr(aomc_pkg::REG_WARMUP, 32'(r));
        rd(aomc_pkg::REG_WARMUP);
        check("pct_rand", rdat, 32'(r));
        wr(aomc_pkg::REG_WARMUP, 32'h32);
        wr(aomc_pkg::REG_SETPT, 32'h002d_c6c0);
        rk[31:0] <= 32'h002c_4020;
        wr(aomc_pkg::REG_CTRL, 32'h042);
        cchk("warm_range_off", 16'sh0);
        wr(aomc_pkg::REG_CTRL, 32'h242);
        mvchk("warm_on", 5000);
        rd(aomc_pkg::REG_STATUS);
        check("warm_status", {30'h0, rdat[1:0]}, 32'h3);
        rk[31:0] <= 32'h002d_c6c0;
        cchk("auto_off", 16'sh0);
        rd(aomc_pkg::REG_CTRL);
        check("auto_off_range", {31'h0, rdat[9]}, 32'h0);
        rk[31:0] <= 32'h002c_4020;
        cchk("stay_off", 16'sh0);
        wr(aomc_pkg::REG_CTRL, 32'h242);
        mvchk("restart", 5000);
        wr(aomc_pkg::REG_CTRL, 32'h642);
        rk[31:0] <= 32'h002d_c6c0;
        cchk("cont_off", 16'sh0);
        rd(aomc_pkg::REG_CTRL);
        check("cont_range", {31'h0, rdat[9]}, 32'h1);
        rk[31:0] <= 32'h002d_b338;
        cchk("cont_hyst", 16'sh0);
        rk[31:0] <= 32'h002d_9fb0;
        mvchk("cont_reon", 5000);
        for (int p = 0; p < 2; p++) begin
            wr(aomc_pkg::REG_CTRL, p ? 32'he42 : 32'h642);
            pwr <= 1'b1;
            @(posedge clk);
            pwr <= 1'b0;
            settle();
            rd(aomc_pkg::REG_CTRL);
            check("power_restore", {31'h0, rdat[9]}, 32'(p));
        end
        pid <= -16'sd1000;
        wr(aomc_pkg::REG_CTRL, 32'h20d);
        cchk("bipolar_loop", -16'sd1000);
        pid <= 16'sh8000;
        cchk("bipolar_clamp", aomc_pkg::DAC_NFS);
        wr(aomc_pkg::REG_CTRL, 32'h205);
        cchk("no_voltage_type", 16'sh0);
        wr(aomc_pkg::REG_SC_POS, 32'h000f_4240);
        wr(aomc_pkg::REG_CTRL, 32'h043);
        for (int i = 0; i < 8; i++) begin
            r = (i == 0) ? 1500000 : $urandom % 1200000;
            rk[31:0] <= 32'(r);
            mvchk("mon_uni", mon_mv(r, 0, 1000000, 0));
        end
        wr(aomc_pkg::REG_CTRL, 32'h047);
        rk[31:0] <= 32'h0007_a120;
        mvchk("mon_bip_mid", 0);
        rk[31:0] <= 32'h0;
        cchk("mon_bip_low", aomc_pkg::DAC_NFS);
        wr(aomc_pkg::REG_SHUT, 32'h1);
        cchk("mon_shutdown", aomc_pkg::DAC_NFS);
        wr(aomc_pkg::REG_CTRL, 32'h007);
        cchk("mon_none", 16'sh0);
        rc[31:0] <= 32'h000f_4240;
        wr(aomc_pkg::REG_CTRL, 32'h053);
        cchk("mon_celsius", aomc_pkg::DAC_FS);
        wr(aomc_pkg::REG_SC_ZERO, -32'sd3000000);
        rd(aomc_pkg::REG_SC_ZERO);
        check("limit_c", rdat, aomc_pkg::C_MIN);
        wr(aomc_pkg::REG_CTRL, 32'h043);
        wr(aomc_pkg::REG_SC_POS, 32'h0100_0000);
        rd(aomc_pkg::REG_SC_POS);
        check("limit_k", rdat, aomc_pkg::K_MAX);
        conclude();
    end
    // cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule
bind aomc_top aomc_sva u_aomc_sva (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
    .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .O_DAC_CODE(O_DAC_CODE), .O_OUT_ACTIVE(O_OUT_ACTIVE));
`default_nettype wire
